// ---- common/ser_ctrl_pkg.sv ----
// Constants shared by the mode and serial control register bank and its bus watchdog.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package ser_ctrl_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // Register offsets on the serial control bus.
  localparam logic [7:0] MODE_ADDR     = 8'h04;
  localparam logic [7:0] CTRL_ADDR     = 8'h05;
  localparam logic [7:0] CRC_LSB_ADDR  = 8'h0a;
  localparam logic [7:0] CRC_MSB_ADDR  = 8'h0b;

  // Reset values and writable-bit masks.
  localparam logic [7:0] MODE_RESET    = 8'h80;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] MODE_WMASK    = 8'haf;
  localparam logic [7:0] CTRL_WMASK    = 8'h1f;

  // Mode register fields.
  localparam int unsigned MODE_IDLE_LOW_BIT   = 7;
  localparam int unsigned MODE_CRC_CLEAR_BIT  = 5;
  localparam int unsigned MODE_LEGACY_OVR_BIT = 3;
  localparam int unsigned MODE_LEGACY_SEL_BIT = 2;
  localparam int unsigned MODE_SLOW_OVR_BIT   = 1;
  localparam int unsigned MODE_SLOW_SEL_BIT   = 0;

  // Control register fields.
  localparam int unsigned CTRL_SDA_DLY_LSB    = 3;
  localparam int unsigned CTRL_SDA_DLY_MSB    = 4;
  localparam int unsigned CTRL_WR_BLOCK_BIT   = 2;
  localparam int unsigned CTRL_WDOG_FAST_BIT  = 1;
  localparam int unsigned CTRL_WDOG_OFF_BIT   = 0;

  // SDA output delay.
  localparam int unsigned SDA_DELAY_BASE_NS = 240;
  localparam int unsigned SDA_DELAY_STEP_NS = 40;
  localparam int unsigned SDA_DELAY_BASE_CYC = SDA_DELAY_BASE_NS / CLK_PERIOD_NS;
  localparam int unsigned SDA_DELAY_STEP_CYC = SDA_DELAY_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned SDA_DELAY_MAX_CYC  = SDA_DELAY_BASE_CYC + 3 * SDA_DELAY_STEP_CYC;

  // Bus watchdog timing.
  localparam int unsigned WDOG_LONG_MS   = 1000;
  localparam int unsigned WDOG_SHORT_US  = 50;
  localparam int unsigned WDOG_LONG_CYC  = WDOG_LONG_MS * (1000000 / CLK_PERIOD_NS);
  localparam int unsigned WDOG_SHORT_CYC = WDOG_SHORT_US * (1000 / CLK_PERIOD_NS);
  localparam int unsigned WDOG_CNT_W     = 27;
  localparam int unsigned RECOVER_HALF_NS  = 5000;
  localparam int unsigned RECOVER_HALF_CYC = RECOVER_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_PULSES   = 9;

  // CRC error counter.
  localparam int unsigned CRC_CNT_W = 16;

  typedef enum logic [2:0] {
    WD_WATCH = 3'b001,
    WD_LOW   = 3'b010,
    WD_HIGH  = 3'b100
  } wdog_state_t;

endpackage

// ---- src/bus_watchdog.sv ----
// Serial control bus watchdog: detects an idle bus and frees a hung one.
// Assumes scl_in and sda_in come straight from pins; they are synchronised here.
module bus_watchdog
  import ser_ctrl_pkg::*;
#(
  parameter int unsigned LONG_CYC  = ser_ctrl_pkg::WDOG_LONG_CYC,
  parameter int unsigned SHORT_CYC = ser_ctrl_pkg::WDOG_SHORT_CYC,
  parameter int unsigned HALF_CYC  = ser_ctrl_pkg::RECOVER_HALF_CYC
)
(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst,
  // Configuration.
  input  wire logic disable_wd,
  input  wire logic speedup,
  // Bus pins.
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Results.
  output logic      scl_oe,
  output logic      bus_free
);

  typedef struct packed {
    logic [1:0]            scl_sync;
    logic [1:0]            sda_sync;
    logic                  scl_prev;
    logic                  sda_prev;
    logic [WDOG_CNT_W-1:0] idle_cnt;
    wdog_state_t           state;
    logic [3:0]            pulses;
    logic [WDOG_CNT_W-1:0] half_cnt;
    logic                  scl_oe;
    logic                  bus_free;
  } wd_state_t;

  wd_state_t s_r;
  wd_state_t s_nxt;
  logic [WDOG_CNT_W-1:0] limit;
  logic                  activity;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.scl_sync = {s_r.scl_sync[0], scl_in};
    s_nxt.sda_sync = {s_r.sda_sync[0], sda_in};
    s_nxt.scl_prev = s_r.scl_sync[1];
    s_nxt.sda_prev = s_r.sda_sync[1];
    s_nxt.bus_free = 1'b0;
    limit = speedup ? WDOG_CNT_W'(SHORT_CYC - 1) : WDOG_CNT_W'(LONG_CYC - 1);
    activity = (s_r.scl_sync[1] != s_r.scl_prev) || (s_r.sda_sync[1] != s_r.sda_prev);
    unique case (s_r.state)
      WD_WATCH:
      begin
        if (disable_wd || activity)
        begin
          s_nxt.idle_cnt = '0;
        end
        else if (s_r.idle_cnt >= limit)
        begin
          s_nxt.idle_cnt = '0;
          if (s_r.sda_sync[1])
          begin
            s_nxt.bus_free = 1'b1;
          end
          else
          begin
            s_nxt.state    = WD_LOW;
            s_nxt.pulses   = '0;
            s_nxt.half_cnt = '0;
            s_nxt.scl_oe   = 1'b1;
          end
        end
        else
        begin
          s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
        end
      end
      WD_LOW:
      begin
        if (s_r.half_cnt >= WDOG_CNT_W'(HALF_CYC - 1))
        begin
          s_nxt.half_cnt = '0;
          s_nxt.scl_oe   = 1'b0;
          s_nxt.pulses   = s_r.pulses + 1'b1;
          s_nxt.state    = WD_HIGH;
        end
        else
        begin
          s_nxt.half_cnt = s_r.half_cnt + 1'b1;
        end
      end
      WD_HIGH:
      begin
        if (s_r.half_cnt >= WDOG_CNT_W'(HALF_CYC - 1))
        begin
          s_nxt.half_cnt = '0;
          if (s_r.pulses >= 4'(RECOVER_PULSES))
          begin
            s_nxt.state = WD_WATCH;
          end
          else
          begin
            s_nxt.scl_oe = 1'b1;
            s_nxt.state  = WD_LOW;
          end
        end
        else
        begin
          s_nxt.half_cnt = s_r.half_cnt + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_r <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1,
               idle_cnt: '0, state: WD_WATCH, pulses: '0, half_cnt: '0,
               scl_oe: 1'b0, bus_free: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign scl_oe   = s_r.scl_oe;
  assign bus_free = s_r.bus_free;

endmodule // bus_watchdog

// ---- src/serializer_mode_and_i2c_ctrl.sv ----
// Mode select and serial control configuration registers, CRC error count, and
// SDA output delay. Register accesses arrive from the serial control bus engine,
// which flags accesses that came across the control channel from the far end.
module serializer_mode_and_i2c_ctrl
  import ser_ctrl_pkg::*;
#(
  parameter int unsigned WDOG_LONG  = ser_ctrl_pkg::WDOG_LONG_CYC,
  parameter int unsigned WDOG_SHORT = ser_ctrl_pkg::WDOG_SHORT_CYC,
  parameter int unsigned RECOVER_HALF = ser_ctrl_pkg::RECOVER_HALF_CYC
)
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst,
  // Register access from the serial control bus engine.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_remote,
  output logic [7:0]      reg_rdata,
  output logic            reg_wr_rejected,
  // Mode pins.
  input  wire logic       legacy_pairing_select_pin,
  input  wire logic       slow_clock_select_pin,
  // Back-channel CRC error events.
  input  wire logic       crc_err_pulse,
  // Effective modes.
  output logic            input_idle_low,
  output logic            legacy_pairing_mode,
  output logic            slow_clock_mode,
  output logic            crc_clear,
  // SDA output from the bus engine, delayed to the pin.
  input  wire logic       sda_drive_req,
  output logic            sda_out,
  output logic            sda_oe,
  // SCL and bus watchdog.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe,
  output logic            bus_free
);

  typedef struct packed {
    logic [7:0]                   mode;
    logic [7:0]                   ctrl;
    logic [CRC_CNT_W-1:0]         crc_cnt;
    logic [1:0]                   legacy_sync;
    logic [1:0]                   slow_sync;
    logic                         legacy_mode;
    logic                         slow_mode;
    logic [SDA_DELAY_MAX_CYC-1:0] sda_line;
    logic                         sda_oe;
    logic [7:0]                   rdata;
    logic                         wr_rejected;
  } regs_t;

  regs_t r_r;
  regs_t r_nxt;
  logic  wd_scl_oe;
  logic  wd_bus_free;

  // Delay line tap that yields the nominal SCL-to-SDA delay for a code.
  function automatic int unsigned sda_tap(input logic [1:0] code);
    sda_tap = SDA_DELAY_BASE_CYC + int'(code) * SDA_DELAY_STEP_CYC - 2;
  endfunction

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.wr_rejected = 1'b0;

    // Pin inputs pass two flip-flops before use.
    r_nxt.legacy_sync = {r_r.legacy_sync[0], legacy_pairing_select_pin};
    r_nxt.slow_sync   = {r_r.slow_sync[0], slow_clock_select_pin};

    // Register writes; remote writes to local registers may be blocked.
    if (reg_wr)
    begin
      if (reg_remote && r_r.ctrl[CTRL_WR_BLOCK_BIT])
      begin
        r_nxt.wr_rejected = 1'b1;
      end
      else if (reg_addr == MODE_ADDR)
      begin
        r_nxt.mode = reg_wdata & MODE_WMASK;
      end
      else if (reg_addr == CTRL_ADDR)
      begin
        r_nxt.ctrl = reg_wdata & CTRL_WMASK;
      end
    end

    // Only local register writes are gated; pass-through traffic never comes here.

    // Effective backward-compatibility and frequency modes.
    r_nxt.legacy_mode = r_r.mode[MODE_LEGACY_OVR_BIT] ?
                        r_r.mode[MODE_LEGACY_SEL_BIT] : r_r.legacy_sync[1];
    r_nxt.slow_mode   = r_r.mode[MODE_SLOW_OVR_BIT] ?
                        r_r.mode[MODE_SLOW_SEL_BIT] : r_r.slow_sync[1];

    // CRC error counter, held at zero while the clear bit is set.
    if (r_r.mode[MODE_CRC_CLEAR_BIT])
    begin
      r_nxt.crc_cnt = '0;
    end
    else if (crc_err_pulse && (r_r.crc_cnt != '1))
    begin
      r_nxt.crc_cnt = r_r.crc_cnt + 1'b1;
    end

    // SDA output delay line.
    r_nxt.sda_line = {r_r.sda_line[SDA_DELAY_MAX_CYC-2:0], sda_drive_req};
    r_nxt.sda_oe   = r_r.sda_line[sda_tap(r_r.ctrl[CTRL_SDA_DLY_MSB:CTRL_SDA_DLY_LSB])];

    // Read data, one cycle after the address is presented.
    unique case (reg_addr)
      MODE_ADDR:    r_nxt.rdata = r_r.mode;
      CTRL_ADDR:    r_nxt.rdata = r_r.ctrl;
      CRC_LSB_ADDR: r_nxt.rdata = r_r.crc_cnt[7:0];
      CRC_MSB_ADDR: r_nxt.rdata = r_r.crc_cnt[15:8];
      default:      r_nxt.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      r_r <= '{mode: MODE_RESET, ctrl: CTRL_RESET, crc_cnt: '0,
               legacy_sync: 2'h0, slow_sync: 2'h0,
               legacy_mode: 1'b0, slow_mode: 1'b0,
               sda_line: '0, sda_oe: 1'b0, rdata: 8'h00, wr_rejected: 1'b0};
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  bus_watchdog #(
    .LONG_CYC  (WDOG_LONG),
    .SHORT_CYC (WDOG_SHORT),
    .HALF_CYC  (RECOVER_HALF)
  ) u_watchdog (
    .clock      (clock),
    .rst        (rst),
    .disable_wd (r_r.ctrl[CTRL_WDOG_OFF_BIT]),
    .speedup    (r_r.ctrl[CTRL_WDOG_FAST_BIT]),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .scl_oe     (wd_scl_oe),
    .bus_free   (wd_bus_free)
  );

  assign reg_rdata           = r_r.rdata;
  assign reg_wr_rejected     = r_r.wr_rejected;
  assign input_idle_low      = r_r.mode[MODE_IDLE_LOW_BIT];
  assign legacy_pairing_mode = r_r.legacy_mode;
  assign slow_clock_mode     = r_r.slow_mode;
  assign crc_clear           = r_r.mode[MODE_CRC_CLEAR_BIT];
  assign sda_out             = 1'b0;
  assign sda_oe              = r_r.sda_oe;
  assign scl_out             = 1'b0;
  assign scl_oe              = wd_scl_oe;
  assign bus_free            = wd_bus_free;

endmodule // serializer_mode_and_i2c_ctrl

// ---- tb/i2c_bus_partner.sv ----
// Open-drain serial control bus with pull-ups and a slave that can hang SDA.
// Assumes output enables are high while a party pulls its line low.
module i2c_bus_partner
(
  // Enables.
  input  wire logic sda_oe,
  input  wire logic scl_oe,
  input  wire logic hold_sda_low,
  // Wire levels.
  output logic      sda_line,
  output logic      scl_line
);
  timeunit 1ns;
  timeprecision 1ps;
  assign sda_line = !(sda_oe || hold_sda_low);
  assign scl_line = !scl_oe;
endmodule // i2c_bus_partner

// ---- tb/ser_ctrl_chk.sv ----
// Checker for the mode and serial control register bank.
// Assumes it is bound to the top module and sees only its ports.
module ser_ctrl_chk
  import ser_ctrl_pkg::*;
#(
  parameter int unsigned RECOVER_HALF = 4
)
(
  // Clock and reset.
  input wire logic       clock,
  input wire logic       rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_remote,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_wr_rejected,
  // Modes and bus.
  input wire logic       input_idle_low,
  input wire logic       legacy_pairing_mode,
  input wire logic       slow_clock_mode,
  input wire logic       crc_clear,
  input wire logic       scl_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] hi_cnt_r;
  logic        mode_wr;
  assign mode_wr = reg_wr && !reg_remote && (reg_addr == MODE_ADDR);
  // Counts how long SCL has been pulled low.
  always_ff @(posedge clock)
  begin
    if (rst || !scl_oe)
      hi_cnt_r <= 16'h0000;
    else
      hi_cnt_r <= hi_cnt_r + 16'h0001;
  end
  property p_idle;
    mode_wr |-> ##1 input_idle_low == $past(reg_wdata[7]);
  endproperty
  a_idle: assert property (p_idle) else $error("idle level wrong");
  property p_clr;
    mode_wr |-> ##1 crc_clear == $past(reg_wdata[5]);
  endproperty
  a_clr: assert property (p_clr) else $error("clear bit wrong");
  property p_legacy;
    mode_wr && reg_wdata[3] |-> ##2 legacy_pairing_mode == $past(reg_wdata[2], 2);
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy mode wrong");
  property p_slow;
    mode_wr && reg_wdata[1] |-> ##2 slow_clock_mode == $past(reg_wdata[0], 2);
  endproperty
  a_slow: assert property (p_slow) else $error("slow mode wrong");
  property p_rej;
    reg_wr_rejected |-> $past(reg_wr && reg_remote);
  endproperty
  a_rej: assert property (p_rej) else $error("reject without remote write");
  property p_resv;
    $past(reg_addr) == MODE_ADDR || $past(reg_addr) == CTRL_ADDR |->
      (reg_rdata & ~($past(reg_addr) == MODE_ADDR ? MODE_WMASK : CTRL_WMASK)) == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_cnt0;
    crc_clear && $past(crc_clear) && $past(crc_clear, 2) && $past(reg_addr) == CRC_LSB_ADDR
      |-> reg_rdata == 8'h00;
  endproperty
  a_cnt0: assert property (p_cnt0) else $error("count not cleared");
  property p_pulse;
    $fell(scl_oe) && !$past(rst) |-> hi_cnt_r == 16'(RECOVER_HALF);
  endproperty
  a_pulse: assert property (p_pulse) else $error("recovery pulse width wrong");
endmodule // ser_ctrl_chk

bind serializer_mode_and_i2c_ctrl ser_ctrl_chk #(.RECOVER_HALF(RECOVER_HALF)) u_chk (
  .clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_remote, .reg_rdata, .reg_wr_rejected,
  .input_idle_low, .legacy_pairing_mode, .slow_clock_mode, .crc_clear, .scl_oe);

// ---- tb/tb.sv ----
// Self-checking bench for the mode and serial control register bank.
// Assumes the package, the design, the checker and the bus model are compiled first.
module tb
  import ser_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG = 200;
  localparam int SHORT = 100;
  localparam int HALF = 4;
  logic       clock, rst, reg_wr, reg_remote, crc_err_pulse, sda_drive_req, hold_sda_low;
  logic       reg_wr_rejected, input_idle_low, legacy_pairing_mode, slow_clock_mode, crc_clear;
  logic       sda_oe, scl_oe, bus_free, sda_line, scl_line, rej, sda_out, scl_out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [1:0] pins;
  int         err_total, tests_run, n, k;
  serializer_mode_and_i2c_ctrl #(.WDOG_LONG(LONG), .WDOG_SHORT(SHORT), .RECOVER_HALF(HALF)) u_dut (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_remote, .reg_rdata, .reg_wr_rejected,
    .legacy_pairing_select_pin(pins[1]), .slow_clock_select_pin(pins[0]), .crc_err_pulse,
    .input_idle_low, .legacy_pairing_mode, .slow_clock_mode, .crc_clear, .sda_drive_req,
    .sda_out, .sda_oe, .scl_in(scl_line), .sda_in(sda_line), .scl_out, .scl_oe, .bus_free);
  i2c_bus_partner u_bus (.sda_oe, .scl_oe, .hold_sda_low, .sda_line, .scl_line);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rm);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_remote = rm;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_remote = 1'b0;
    rej = reg_wr_rejected;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    reg_addr = a;
    repeat (2) @(negedge clock);
    rd_val = reg_rdata;
  endtask
  task automatic wait_v(input int s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while ((s == 0 ? sda_oe : s == 1 ? bus_free : scl_oe) !== v)
    begin
      @(negedge clock);
      cnt++;
      if (cnt > lim)
      begin
        check("timeout", 16'h0000, 16'h0001);
        stop_test();
      end
    end
  endtask
  task automatic crc_err(input int cnt);
    repeat (3) @(negedge clock);
    crc_err_pulse = 1'b1;
    repeat (cnt) @(negedge clock);
    crc_err_pulse = 1'b0;
  endtask
  task automatic t_regs();
    rd(MODE_ADDR);
    check("mode reset", rd_val, MODE_RESET);
    check("idle low", input_idle_low, 1'b1);
    rd(CTRL_ADDR);
    check("ctrl reset", rd_val, CTRL_RESET);
    rd(8'h07);
    check("unmapped", rd_val, 8'h00);
    wr(MODE_ADDR, 8'h5f, 1'b0);
    rd(MODE_ADDR);
    check("mode mask", rd_val, 8'h0f);
    check("idle high", input_idle_low, 1'b0);
    wr(CTRL_ADDR, 8'hff, 1'b0);
    rd(CTRL_ADDR);
    check("ctrl mask", rd_val, 8'h1f);
    $display("test regs done");
  endtask
  task automatic t_modes();
    logic [1:0] v;
    wr(MODE_ADDR, 8'h80, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      v = i[1:0];
      pins = i < 4 ? v : ~v;
      if (i >= 4)
        wr(MODE_ADDR, {5'b10001, v[1], 1'b1, v[0]}, 1'b0);
      repeat (5) @(negedge clock);
      check("legacy mode", legacy_pairing_mode, v[1]);
      check("slow mode", slow_clock_mode, v[0]);
    end
    $display("test modes done");
  endtask
  task automatic t_crc();
    wr(MODE_ADDR, 8'h80, 1'b0);
    crc_err(3);
    rd(CRC_LSB_ADDR);
    check("crc low", rd_val, 8'h03);
    rd(CRC_MSB_ADDR);
    check("crc high", rd_val, 8'h00);
    wr(MODE_ADDR, 8'ha0, 1'b0);
    crc_err(1);
    rd(CRC_LSB_ADDR);
    check("crc held", rd_val, 8'h00);
    check("clear out", crc_clear, 1'b1);
    wr(MODE_ADDR, 8'h80, 1'b0);
    crc_err(1);
    rd(CRC_LSB_ADDR);
    check("crc resumed", rd_val, 8'h01);
    $display("test crc done");
  endtask
  task automatic t_block();
    wr(CTRL_ADDR, 8'h04, 1'b0);
    wr(MODE_ADDR, 8'h00, 1'b1);
    check("rejected", rej, 1'b1);
    rd(MODE_ADDR);
    check("blocked", rd_val, 8'h80);
    wr(CTRL_ADDR, 8'h00, 1'b0);
    check("local ok", rej, 1'b0);
    wr(MODE_ADDR, 8'h00, 1'b1);
    check("remote ok", rej, 1'b0);
    rd(MODE_ADDR);
    check("remote stored", rd_val, 8'h00);
    $display("test block done");
  endtask
  task automatic t_sda();
    for (int c = 0; c < 4; c++)
    begin
      wr(CTRL_ADDR, {3'b000, c[1:0], 3'b000}, 1'b0);
      sda_drive_req = 1'b1;
      wait_v(0, 1'b1, 60, n);
      check("sda delay", 16'(n), 16'(SDA_DELAY_BASE_CYC + c * SDA_DELAY_STEP_CYC));
      sda_drive_req = 1'b0;
      wait_v(0, 1'b0, 60, n);
      repeat (SDA_DELAY_MAX_CYC) @(negedge clock);
    end
    check("sda level", sda_out, 1'b0);
    $display("test sda done");
  endtask
  task automatic t_wdog();
    logic prev;
    for (int f = 0; f < 2; f++)
    begin
      k = f == 0 ? LONG : SHORT;
      wr(CTRL_ADDR, {6'h00, f[0], 1'b0}, 1'b0);
      wait_v(1, 1'b1, 3 * LONG, n);
      @(negedge clock);
      wait_v(1, 1'b1, 3 * LONG, n);
      check("free period", 16'(n + 1 >= k && n + 1 <= k + 2), 16'h0001);
    end
    wr(CTRL_ADDR, 8'h03, 1'b0);
    hold_sda_low = 1'b1;
    k = 0;
    repeat (3 * SHORT)
    begin
      @(negedge clock);
      k += int'(bus_free === 1'b1 || scl_oe === 1'b1);
    end
    check("wdog off", 16'(k), 16'h0000);
    wr(CTRL_ADDR, 8'h02, 1'b0);
    wait_v(2, 1'b1, 3 * SHORT, n);
    k = 1;
    prev = scl_oe;
    repeat (20 * HALF)
    begin
      @(negedge clock);
      k += int'(scl_oe === 1'b1 && scl_line === 1'b0 && prev === 1'b0);
      prev = scl_oe;
    end
    check("recovery pulses", 16'(k), 16'(RECOVER_PULSES));
    check("scl level", scl_out, 1'b0);
    hold_sda_low = 1'b0;
    $display("test wdog done");
  endtask
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_remote = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    crc_err_pulse = 1'b0;
    sda_drive_req = 1'b0;
    hold_sda_low = 1'b0;
    pins = 2'b00;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_regs();
    t_modes();
    t_crc();
    t_block();
    t_sda();
    t_wdog();
    stop_test();
  end
endmodule // tb
